// File: pkg/icfe_pkg.sv
`default_nettype none
package icfe_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTL0 = 8'h14;
  localparam logic [7:0] OFS_CTL1 = 8'h18;
  localparam logic [7:0] OFS_STS = 8'h1c;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_CMP = 8'h24;
  localparam logic [7:0] OFS_CNT = 8'h28;
  // Reset values
  localparam logic [31:0] CTL0_RST = 32'h0000_0000;
  localparam logic [31:0] CTL1_RST = 32'h0000_0000;
  localparam logic [5:0] STS_RST = 6'h00;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [23:0] CMP_RST = 24'h00_0000;
  localparam logic [23:0] CNT_RST = 24'h00_0000;
  // Writable bits
  localparam logic [31:0] CTL0_WMASK = 32'h0900_3f7b;
  localparam logic [31:0] CTL1_WMASK = 32'h0003_773f;
  localparam logic [5:0] MASK_WMASK = 6'h27;
  // Field positions, first control register
  localparam int NFPRE_LSB = 0;
  localparam int BYP_BIT = 3;
  localparam int GATE_LSB = 4;
  localparam int SRC_LSB = 8;
  localparam int RUN_BIT = 24;
  localparam int RLD_BIT = 27;
  // Field positions, second control register
  localparam int EDGE_LSB = 0;
  localparam int RLDS_LSB = 8;
  localparam int DIV_LSB = 12;
  localparam int CSRC_LSB = 16;
  // Field positions, status register
  localparam int OVF_BIT = 5;
  localparam int LVL_LSB = 8;
  // Reload trigger codes
  localparam logic [2:0] RLDS_TF0 = 3'h0;
  localparam logic [2:0] RLDS_TF1 = 3'h1;
  localparam logic [2:0] RLDS_TF2 = 3'h2;
  localparam logic [2:0] RLDS_OVF = 3'h4;
  // Counter
  localparam logic [23:0] CNT_MAX = 24'hff_ffff;
  // Filter: last count value; three samples must agree before the level moves
  localparam logic [1:0] FILT_LAST = 2'h2;
  // Divider terminal counts (ratio minus one)
  localparam logic [3:0] NF_LIM [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
  localparam logic [6:0] DIV_LIM [8] = '{7'h00, 7'h03, 7'h0f, 7'h1f,
                                         7'h3f, 7'h5f, 7'h6f, 7'h7f};
endpackage : icfe_pkg
`default_nettype wire

// File: rtl/icfe_sync.sv
`timescale 1ns/10ps
`default_nettype none
module icfe_sync #(
  parameter int W = 6
) (
  input wire logic i_clk,          // Module clock
  input wire logic i_nrst,         // Sync reset, active low
  input wire logic [W-1:0] i_d,    // Asynchronous inputs
  output logic [W-1:0] o_q         // Settled levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } icfe_sync_t;
  icfe_sync_t r;
  icfe_sync_t n;
  always_comb begin
    n = r;
    n.s1 = i_d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // Level moves only where stages two and three agree
    n.q = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign o_q = r.q;
endmodule : icfe_sync
`default_nettype wire

// File: rtl/icfe_div.sv
`timescale 1ns/10ps
`default_nettype none
module icfe_div #(
  parameter int W = 7
) (
  input wire logic i_clk,          // Module clock
  input wire logic i_nrst,         // Sync reset, active low
  input wire logic i_tick,         // Input tick
  input wire logic [W-1:0] i_lim,  // Ratio minus one
  output logic o_tick              // One tick per ratio input ticks
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } icfe_div_t;
  icfe_div_t r;
  icfe_div_t n;
  logic last;
  // Also catches a limit lowered below the running count
  assign last = (r.cnt >= i_lim);
  assign o_tick = i_tick && last;
  always_comb begin
    n = r;
    if (i_tick) begin
      n.cnt = last ? '0 : W'(r.cnt + 1'b1);
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : icfe_div
`default_nettype wire

// File: rtl/icfe_top.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Source select routes pin, comparators or converter
// - Pin gate bits block port pins
// - Filter active unless bypass bit set
// - Filter sampling at clock over 1,2,4,16
// - Counter clock: module clock or channel input
// - Pre-divider ratios 1,4,16,32,64,96,112,128
// - Trigger event loads compare value into counter
// - Trigger codes: channels 0-2, or overflow
// - Per-channel edge: rising, falling or both
// - Second control register at 0x18, resets zero
// - Reload enable clear blocks every reload
// - Run bit starts and stops counting
// - 24-bit counter, overflow on wrap to zero
module icfe_top (
  input wire logic i_clk,           // Module clock, 20 MHz
  input wire logic i_nrst,          // Sync reset, active low
  input wire logic i_psel,          // APB select
  input wire logic i_penable,       // APB enable
  input wire logic i_pwrite,        // APB direction
  input wire logic [7:0] i_paddr,   // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata,     // APB read data
  output logic o_pready,            // APB ready
  output logic o_pslverr,           // APB error, unmapped address
  input wire logic [2:0] i_capture_pin, // Port pins 2..0
  input wire logic i_comparator_a_output, // Comparator A
  input wire logic i_comparator_b_output, // Comparator B
  input wire logic i_converter_compare_output, // Converter compare
  output logic o_irq,               // Interrupt, level
  output logic [2:0] o_chan_level   // Filtered channel levels
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC = 2'b10
  } icfe_st_t;

  typedef struct packed {
    icfe_st_t st;
    logic rdy;
    logic err;
    logic [31:0] rdata;
    logic [31:0] ctl0;
    logic [31:0] ctl1;
    logic [5:0] sts;
    logic [5:0] mask;
    logic [23:0] cmp;
    logic [23:0] cnt;
    logic [2:0] lvl;
    logic [2:0][1:0] fcnt;
    logic [2:0] prev;
    logic irq;
  } icfe_state_t;

  icfe_state_t r;
  icfe_state_t n;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == icfe_pkg::OFS_CTL0) || (a == icfe_pkg::OFS_CTL1) ||
               (a == icfe_pkg::OFS_STS) || (a == icfe_pkg::OFS_MASK) ||
               (a == icfe_pkg::OFS_CMP) || (a == icfe_pkg::OFS_CNT);
  endfunction : addr_hit

  function automatic logic src_mux(input logic [1:0] sel, input logic pin,
                                   input logic ca, input logic cb,
                                   input logic cv);
    case (sel)
      2'h0: src_mux = pin;
      2'h1: src_mux = ca;
      2'h2: src_mux = cb;
      default: src_mux = cv;
    endcase
  endfunction : src_mux

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    if (sel[1]) begin
      edge_hit = rise | fall;
    end else if (sel[0]) begin
      edge_hit = fall;
    end else begin
      edge_hit = rise;
    end
  endfunction : edge_hit

  // Control fields
  logic [1:0] nf_pre;
  logic byp;
  logic [2:0] gate;
  logic run;
  logic rld_en;
  logic [2:0] rlds;
  logic [2:0] div_sel;
  logic [1:0] csrc;
  assign nf_pre = r.ctl0[icfe_pkg::NFPRE_LSB +: 2];
  assign byp = r.ctl0[icfe_pkg::BYP_BIT];
  assign gate = r.ctl0[icfe_pkg::GATE_LSB +: 3];
  assign run = r.ctl0[icfe_pkg::RUN_BIT];
  assign rld_en = r.ctl0[icfe_pkg::RLD_BIT];
  assign rlds = r.ctl1[icfe_pkg::RLDS_LSB +: 3];
  assign div_sel = r.ctl1[icfe_pkg::DIV_LSB +: 3];
  assign csrc = r.ctl1[icfe_pkg::CSRC_LSB +: 2];

  // Inputs from outside the clock domain
  logic [5:0] s_in;
  icfe_sync #(.W(6)) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d({i_converter_compare_output, i_comparator_b_output,
          i_comparator_a_output, i_capture_pin}),
    .o_q(s_in)
  );

  // Per-channel source, filter output and edges
  logic [2:0] raw;
  logic [2:0] filt;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] cap_evt;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      assign raw[g] = src_mux(r.ctl0[icfe_pkg::SRC_LSB + 2*g +: 2],
                              s_in[g] & gate[g], s_in[3], s_in[4],
                              s_in[5]);
      assign filt[g] = byp ? raw[g] : r.lvl[g];
      assign rise[g] = filt[g] && !r.prev[g];
      assign fall[g] = !filt[g] && r.prev[g];
      assign cap_evt[g] = edge_hit(r.ctl1[icfe_pkg::EDGE_LSB + 2*g +: 2],
                                   rise[g], fall[g]);
    end
  endgenerate

  // Filter sampling tick
  logic nf_tick;
  icfe_div #(.W(4)) u_nfdiv (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(1'b1),
    .i_lim(icfe_pkg::NF_LIM[nf_pre]),
    .o_tick(nf_tick)
  );

  // Counter clock: source select, then pre-divider
  logic src_tick;
  logic div_tick;
  assign src_tick = (csrc == 2'h0) ? 1'b1 : rise[csrc - 2'h1];
  icfe_div #(.W(7)) u_cdiv (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(run && src_tick),
    .i_lim(icfe_pkg::DIV_LIM[div_sel]),
    .o_tick(div_tick)
  );

  // Overflow and reload trigger
  logic wrap;
  logic trig;
  logic reload_evt;
  assign wrap = div_tick && (r.cnt == icfe_pkg::CNT_MAX);
  always_comb begin
    case (rlds)
      icfe_pkg::RLDS_TF0: trig = cap_evt[0];
      icfe_pkg::RLDS_TF1: trig = cap_evt[1];
      icfe_pkg::RLDS_TF2: trig = cap_evt[2];
      icfe_pkg::RLDS_OVF: trig = wrap;
      default: trig = 1'b0;
    endcase
  end
  assign reload_evt = rld_en && trig;

  logic [31:0] rd_mux;
  always_comb begin
    case (i_paddr)
      icfe_pkg::OFS_CTL0: rd_mux = r.ctl0;
      icfe_pkg::OFS_CTL1: rd_mux = r.ctl1;
      icfe_pkg::OFS_STS: rd_mux = {21'h0, r.prev, 2'h0, r.sts};
      icfe_pkg::OFS_MASK: rd_mux = {26'h0, r.mask};
      icfe_pkg::OFS_CMP: rd_mux = {8'h0, r.cmp};
      icfe_pkg::OFS_CNT: rd_mux = {8'h0, r.cnt};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    n = r;
    // Bus slave: answer registered in setup, taken in access
    case (r.st)
      ST_IDLE: begin
        n.rdy = 1'b0;
        n.err = 1'b0;
        if (i_psel && !i_penable) begin
          n.st = ST_ACC;
          n.rdy = 1'b1;
          n.err = !addr_hit(i_paddr);
          n.rdata = i_pwrite ? 32'h0000_0000 : rd_mux;
        end
      end
      ST_ACC: begin
        n.st = ST_IDLE;
        n.rdy = 1'b0;
        n.err = 1'b0;
        if (i_psel && i_penable && i_pwrite) begin
          case (i_paddr)
            icfe_pkg::OFS_CTL0: n.ctl0 = i_pwdata & icfe_pkg::CTL0_WMASK;
            icfe_pkg::OFS_CTL1: n.ctl1 = i_pwdata & icfe_pkg::CTL1_WMASK;
            icfe_pkg::OFS_MASK: n.mask = i_pwdata[5:0] & icfe_pkg::MASK_WMASK;
            icfe_pkg::OFS_CMP: n.cmp = i_pwdata[23:0];
            default: n.cmp = r.cmp;
          endcase
        end else if (i_psel && i_penable && i_paddr == icfe_pkg::OFS_STS) begin
          // Clear only what the read returned
          n.sts = r.sts & ~r.rdata[5:0];
        end
      end
      default: begin
        n.st = ST_IDLE;
        n.rdy = 1'b0;
        n.err = 1'b0;
      end
    endcase

    // Noise filter per channel
    for (int i = 0; i < 3; i++) begin
      if (byp) begin
        n.lvl[i] = raw[i];
        n.fcnt[i] = 2'h0;
      end else if (nf_tick) begin
        if (raw[i] == r.lvl[i]) begin
          n.fcnt[i] = 2'h0;
        end else if (r.fcnt[i] == icfe_pkg::FILT_LAST) begin
          n.lvl[i] = raw[i];
          n.fcnt[i] = 2'h0;
        end else begin
          n.fcnt[i] = r.fcnt[i] + 2'h1;
        end
      end
    end
    n.prev = filt;

    // Counter: reload has priority over counting
    if (reload_evt) begin
      n.cnt = r.cmp;
    end else if (div_tick) begin
      n.cnt = r.cnt + 24'h00_0001;
    end

    // Events set after the clear, so a set wins
    n.sts[2:0] = n.sts[2:0] | cap_evt;
    n.sts[icfe_pkg::OVF_BIT] = n.sts[icfe_pkg::OVF_BIT] | wrap;
    n.irq = |(n.sts & n.mask);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      r.st <= ST_IDLE;
      r.rdy <= 1'b0;
      r.err <= 1'b0;
      r.rdata <= 32'h0000_0000;
      r.ctl0 <= icfe_pkg::CTL0_RST;
      r.ctl1 <= icfe_pkg::CTL1_RST;
      r.sts <= icfe_pkg::STS_RST;
      r.mask <= icfe_pkg::MASK_RST;
      r.cmp <= icfe_pkg::CMP_RST;
      r.cnt <= icfe_pkg::CNT_RST;
      r.lvl <= 3'h0;
      r.fcnt <= '0;
      r.prev <= 3'h0;
      r.irq <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign o_prdata = r.rdata;
  assign o_pready = r.rdy;
  assign o_pslverr = r.err;
  assign o_irq = r.irq;
  assign o_chan_level = r.prev;

  default clocking cb_main @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  AST_SRC_CMP: assert property (
    (r.ctl0[icfe_pkg::SRC_LSB +: 2] == 2'h2) |-> (raw[0] == s_in[4]))
    else $error("Channel 0 not routed from comparator B");

  AST_GATE: assert property (
    (!gate[1] && r.ctl0[icfe_pkg::SRC_LSB + 2 +: 2] == 2'h0) |-> !raw[1])
    else $error("Gated pin 1 reached the channel");

  AST_BYPASS: assert property (
    (byp && $past(byp)) |-> (r.prev == $past(raw)))
    else $error("Bypassed filter delayed the input");

  AST_NF_DIV2: assert property (
    (nf_tick && nf_pre == 2'h1 && !byp) |=> !nf_tick)
    else $error("Filter sample tick too fast for divide by two");

  AST_CLK_MOD: assert property (
    (run && csrc == 2'h0 && div_sel == 3'h0) |-> div_tick)
    else $error("Module clock source did not tick every cycle");

  AST_DIV4: assert property (
    (div_tick && run && csrc == 2'h0 && div_sel == 3'h1)
    ##1 (run && csrc == 2'h0 && div_sel == 3'h1) [*4]
    |-> (div_tick && !$past(div_tick, 1) && !$past(div_tick, 2) && !$past(div_tick, 3)))
    else $error("Pre-divider four wrong");

  AST_RELOAD: assert property (
    reload_evt |=> (r.cnt == $past(r.cmp)))
    else $error("Reload did not load the compare value");

  AST_TRIG_OVF: assert property (
    (rld_en && rlds == icfe_pkg::RLDS_OVF && wrap) |=> (r.cnt == $past(r.cmp)))
    else $error("Overflow trigger did not reload");

  AST_EDGE_FALL: assert property (
    (r.ctl1[icfe_pkg::EDGE_LSB + 4 +: 2] == 2'h1 && cap_evt[2])
    |=> (!r.prev[2] && $past(r.prev[2])))
    else $error("Falling-edge select fired without a fall");

  AST_RST: assert property (disable iff (1'b0)
    !i_nrst |=> (r.ctl1 == 32'h0000_0000 && r.cnt == 24'h00_0000))
    else $error("Control not zero after reset");

  AST_NO_RLD: assert property (
    (!rld_en && !div_tick) |=> (r.cnt == $past(r.cnt)))
    else $error("Counter changed with reload disabled and no tick");

  AST_STOP: assert property (
    (!run && !reload_evt) |=> $stable(r.cnt))
    else $error("Counter moved while stopped");

  AST_OVF: assert property (
    (wrap && !reload_evt) |=> (r.cnt == 24'h00_0000 && r.sts[icfe_pkg::OVF_BIT]))
    else $error("Wrap did not give zero and overflow flag");

  AST_RSV: assert property (
    (rlds == 3'h3 || rlds > 3'h4) |-> !reload_evt)
    else $error("Reserved trigger code reloaded");

  AST_IRQ: assert property (
    (|(r.sts & r.mask)) |-> o_irq)
    else $error("Unmasked status without interrupt");

endmodule : icfe_top
`default_nettype wire

// File: tb/icfe_src.sv
`timescale 1ns/10ps
`default_nettype none
module icfe_src (
  input wire logic i_clk,       // Module clock
  input wire logic [5:0] i_set, // Wanted levels: cvt, cmp b, cmp a, pins 2..0
  output logic [2:0] o_pin,     // Port pins 2..0
  output logic o_cmp_a,         // Comparator A
  output logic o_cmp_b,         // Comparator B
  output logic o_cvt            // Converter compare
);
  // Outside levels move only just after a clock edge
  always_ff @(posedge i_clk) begin
    {o_cvt, o_cmp_b, o_cmp_a, o_pin} <= i_set;
  end
endmodule : icfe_src
`default_nettype wire

// File: tb/icfe_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module icfe_top_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [2:0] lvl;
  logic [2:0] pin;
  logic ca;
  logic cb;
  logic cv;
  logic [5:0] src = 6'h00;
  logic [31:0] rd;
  logic er;
  logic [23:0] c0;
  int err_count = 0;
  int n_compared = 0;
  localparam logic [31:0] BASE = 32'h0000_0078;
  localparam logic [31:0] RUN = 32'h0100_0000;

  always #25 clk = ~clk;

  icfe_src u_icfe_src (.i_clk(clk), .i_set(src), .o_pin(pin), .o_cmp_a(ca), .o_cmp_b(cb),
    .o_cvt(cv));
  icfe_top u_icfe_top (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_capture_pin(pin),
    .i_comparator_a_output(ca), .i_comparator_b_output(cb),
    .i_converter_compare_output(cv), .o_irq(irq), .o_chan_level(lvl));

  task end_of_test;
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rdr

  task toggle(input int s);
    @(posedge clk);
    src[s] <= ~src[s];
  endtask : toggle

  // Bounded wait for a channel level to move, then let flags settle
  task wait_chg(input int ch);
    logic v0;
    int n;
    v0 = lvl[ch];
    n = 0;
    while (lvl[ch] === v0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
  endtask : wait_chg

  task t_regs;
    rdr(icfe_pkg::OFS_CTL1);
    cmp("ctl1 reset", icfe_pkg::CTL1_RST, rd);
    wr(icfe_pkg::OFS_CTL1, 32'hffff_ffff);
    rdr(icfe_pkg::OFS_CTL1);
    cmp("ctl1 fields", icfe_pkg::CTL1_WMASK, rd);
    rdr(8'h40);
    cmp("unmapped", 32'h1, {31'h0, er});
  endtask : t_regs

  task t_route;
    int s;
    for (int c = 0; c < 4; c++) begin
      s = (c == 0) ? 0 : c + 2;
      wr(icfe_pkg::OFS_CTL0, BASE | (32'(c) << 8));
      wr(icfe_pkg::OFS_CTL1, 32'h0000_0002);
      wr(icfe_pkg::OFS_MASK, 32'h0000_0001);
      repeat (10) @(posedge clk);
      rdr(icfe_pkg::OFS_STS);
      toggle(s);
      wait_chg(0);
      cmp("irq raised", 32'h1, {31'h0, irq});
      wr(icfe_pkg::OFS_MASK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      cmp("irq masked", 32'h0, {31'h0, irq});
      wr(icfe_pkg::OFS_MASK, 32'h0000_0001);
      rdr(icfe_pkg::OFS_STS);
      cmp("chan0 flag", 32'h1, {31'h0, rd[0]});
      repeat (2) @(posedge clk);
      cmp("irq cleared", 32'h0, {31'h0, irq});
    end
  endtask : t_route

  task t_gate;
    wr(icfe_pkg::OFS_CTL0, 32'h0000_0058);
    toggle(1);
    repeat (40) @(posedge clk);
    cmp("gated level", 32'h0, {31'h0, lvl[1]});
    wr(icfe_pkg::OFS_CTL0, BASE);
    wait_chg(1);
    cmp("open level", 32'h1, {31'h0, lvl[1]});
  endtask : t_gate

  task t_edge;
    logic ex;
    for (int e = 0; e < 3; e++) begin
      for (int k = 0; k < 2; k++) begin
        wr(icfe_pkg::OFS_CTL1, 32'(e) << 4);
        repeat (10) @(posedge clk);
        rdr(icfe_pkg::OFS_STS);
        toggle(2);
        wait_chg(2);
        ex = (e == 2) || (src[2] ? e == 0 : e == 1);
        rdr(icfe_pkg::OFS_STS);
        cmp("edge flag", {31'h0, ex}, {31'h0, rd[2]});
      end
    end
  endtask : t_edge

  // Pulse on pin 0 and report whether a capture was flagged
  task pulse(input logic [31:0] ctl, input int len);
    wr(icfe_pkg::OFS_CTL0, ctl);
    wr(icfe_pkg::OFS_CTL1, 32'h0000_0002);
    repeat (60) @(posedge clk);
    rdr(icfe_pkg::OFS_STS);
    @(posedge clk);
    src[0] <= 1'b1;
    repeat (len) @(posedge clk);
    src[0] <= 1'b0;
    repeat (100) @(posedge clk);
    rdr(icfe_pkg::OFS_STS);
  endtask : pulse

  task t_filter;
    static int sh[4] = '{2, 4, 8, 20};
    static int lg[4] = '{8, 12, 24, 80};
    @(posedge clk);
    src[0] <= 1'b0;
    pulse(BASE, 2);
    cmp("bypass pulse", 32'h1, {31'h0, rd[0]});
    for (int p = 0; p < 4; p++) begin
      pulse(32'h0000_0070 | 32'(p), sh[p]);
      cmp("short pulse", 32'h0, {31'h0, rd[0]});
      pulse(32'h0000_0070 | 32'(p), lg[p]);
      cmp("long pulse", 32'h1, {31'h0, rd[0]});
    end
  endtask : t_filter

  task t_count;
    static int r[8] = '{1, 4, 16, 32, 64, 96, 112, 128};
    int d;
    for (int i = 0; i < 9; i++) begin
      wr(icfe_pkg::OFS_CTL1, 32'(i % 8) << 12);
      wr(icfe_pkg::OFS_CTL0, (i < 8) ? BASE | RUN : BASE);
      rdr(icfe_pkg::OFS_CNT);
      c0 = rd[23:0];
      repeat (512) @(posedge clk);
      rdr(icfe_pkg::OFS_CNT);
      d = int'(rd[23:0] - c0);
      if (i < 8) cmp("rate", 32'h1, {31'h0, d * r[i] > 515 - r[i] && d * r[i] < 515 + r[i]});
      else cmp("stopped", {8'h0, c0}, {8'h0, rd[23:0]});
    end
  endtask : t_count

  task t_csrc;
    for (int c = 1; c < 4; c++) begin
      wr(icfe_pkg::OFS_CTL1, (32'(c) << 16) | 32'h0000_1000);
      wr(icfe_pkg::OFS_CTL0, BASE | RUN);
      rdr(icfe_pkg::OFS_CNT);
      c0 = rd[23:0];
      repeat (16) begin
        toggle(c - 1);
        repeat (10) @(posedge clk);
      end
      rdr(icfe_pkg::OFS_CNT);
      cmp("input count", {8'h0, c0 + 24'h2}, {8'h0, rd[23:0]});
    end
  endtask : t_csrc

  task rcase(input logic [2:0] code, input logic en, input int ch, input logic hi);
    wr(icfe_pkg::OFS_CTL1, {21'h0, code, 8'h2a});
    wr(icfe_pkg::OFS_CTL0, BASE | RUN | (en ? 32'h0800_0000 : 32'h0));
    repeat (300) @(posedge clk);
    toggle(ch);
    wait_chg(ch);
    rdr(icfe_pkg::OFS_CNT);
    cmp("reloaded", {31'h0, hi}, {31'h0, rd[23:0] >= 24'hff_ff00});
  endtask : rcase

  task t_reload;
    wr(icfe_pkg::OFS_CMP, 32'h00ff_ff00);
    for (int i = 0; i < 3; i++) rcase(3'(i), 1'b1, i, 1'b1);
    rcase(3'h3, 1'b1, 0, 1'b0);
    rcase(3'h0, 1'b0, 0, 1'b0);
    rcase(3'h0, 1'b1, 0, 1'b1);
    rdr(icfe_pkg::OFS_STS);
    wr(icfe_pkg::OFS_CTL1, 32'h0000_042a);
    repeat (300) @(posedge clk);
    rdr(icfe_pkg::OFS_STS);
    cmp("overflow flag", 32'h1, {31'h0, rd[5]});
    rdr(icfe_pkg::OFS_CNT);
    cmp("overflow reload", 32'h1, {31'h0, rd[23:0] >= 24'hff_ff00});
  endtask : t_reload

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_route();
    t_gate();
    t_edge();
    t_filter();
    t_count();
    t_csrc();
    t_reload();
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule : icfe_top_tb
`default_nettype wire
